/* File: hdl/acqmr_top.sv */
`timescale 1ns/1ps
`default_nettype none

module acqmr_top
  import acqmr_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // converter side
  input wire logic adc_sample_stb,
  input wire logic [DATA_W-1:0] adc_data,
  // internal bus view
  output logic hs_clk_pulse,
  output logic [DATA_W-1:0] hs_bus_data,
  output logic [ADDR_W-1:0] mem_addr
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (ADDR_W < 18 || ADDR_W > 20)
    begin : g_bad_addr
      $error("acqmr_top: ADDR_W must be 18 to 20");
    end
    if (DATA_W < 1 || DATA_W > 8)
    begin : g_bad_data
      $error("acqmr_top: DATA_W must be 1 to 8");
    end
  endgenerate

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [19:0] seg_end(input logic [7:0] term);
    logic [8:0] t1;
    t1 = {1'b0, term} + 9'h001;
    seg_end = {t1, SEG_END_LOW_FILL};
  endfunction : seg_end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] route_q;
  logic [7:0] mode_q;
  logic [7:0] seg_end_q;
  logic [7:0] start_hi_q;
  logic [7:0] start_lo_q;
  logic [7:0] rdata_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] end_addr;
  logic [DATA_W-1:0] stage1_q;
  logic [DATA_W-1:0] stage2_q;
  logic [DATA_W-1:0] mem_q;
  logic [DATA_W-1:0] bus_data_q;
  logic pulse_q;
  logic [19:0] end_full;
  logic base_load;
  logic strobe_acc;
  logic readout_rd;
  logic tick;
  logic read_mode;
  logic write_mode;
  logic mem_drives;
  logic adc_drives;
  acqmr_clk_src_t clk_src;

  assign clk_src = acqmr_clk_src_t'(route_q[CLK_SRC_MSB:CLK_SRC_LSB]);
  assign mem_drives = (route_q[DATA_SRC_MSB:DATA_SRC_LSB] == SRC_MEMORY);
  assign adc_drives = (route_q[DATA_SRC_MSB:DATA_SRC_LSB] == SRC_ADC);
  assign read_mode = (mode_q[MODE_MSB:0] == MODE_READ);
  assign write_mode = (mode_q[MODE_MSB:0] == MODE_WRITE);
  assign strobe_acc = (reg_wr || reg_rd) && hit(reg_addr, ADR_CLK_STROBE);
  assign readout_rd = reg_rd && hit(reg_addr, ADR_READOUT);
  assign base_load = reg_wr && hit(reg_addr, ADR_START_LO);

  // ----------------------------------------
  // bus clock source select
  // ----------------------------------------
  always_comb
  begin
    case (clk_src)
      CLK_STROBE: tick = strobe_acc;
      CLK_READOUT: tick = readout_rd;
      CLK_ADC: tick = adc_sample_stb;
      CLK_NONE: tick = 1'b0;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // segment addresses
  // ----------------------------------------
  assign end_full = seg_end(seg_end_q);
  assign end_addr = end_full[ADDR_W-1:0];
  // overflow bit of start/4 rides in the terminal value
  assign base_addr = ADDR_W'({seg_end_q[0], start_hi_q, start_lo_q, 2'b00});

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      route_q <= REG_RESET;
    end
    else if (reg_wr && hit(reg_addr, ADR_BUS_ROUTE))
    begin
      route_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_q <= REG_RESET;
    end
    else if (reg_wr && hit(reg_addr, ADR_MEM_MODE))
    begin
      mode_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      seg_end_q <= REG_RESET;
      start_hi_q <= REG_RESET;
      start_lo_q <= REG_RESET;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, ADR_SEG_END))
      begin
        seg_end_q <= reg_wdata;
      end
      if (hit(reg_addr, ADR_START_HI))
      begin
        start_hi_q <= reg_wdata;
      end
      if (hit(reg_addr, ADR_START_LO))
      begin
        start_lo_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // address counter
  // ----------------------------------------
  // a low start byte write loads the counter with the full base
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addr_q <= '0;
    end
    else if (base_load)
    begin
      addr_q <= ADDR_W'({seg_end_q[0], start_hi_q, reg_wdata, 2'b00});
    end
    else if (tick && (read_mode || write_mode))
    begin
      if (read_mode && addr_q == end_addr)
      begin
        addr_q <= base_addr;
      end
      else
      begin
        addr_q <= addr_q + ADDR_W'(1);
      end
    end
  end

  // ----------------------------------------
  // memory and transfer stages
  // ----------------------------------------
  acqmr_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .addr(addr_q),
    .wr_en(tick && write_mode && adc_drives),
    .wr_data(adc_data),
    .rd_en(tick && read_mode),
    .rd_data_q(mem_q)
  );

  // three bus clocks fill memory output, stage1 and stage2
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else if (tick && read_mode)
    begin
      stage1_q <= mem_q;
      stage2_q <= stage1_q;
    end
  end

  // ----------------------------------------
  // internal bus view
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pulse_q <= 1'b0;
      bus_data_q <= '0;
    end
    else
    begin
      pulse_q <= tick;
      if (tick && mem_drives)
      begin
        bus_data_q <= stage2_q;
      end
      else if (tick && adc_drives)
      begin
        bus_data_q <= adc_data;
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_q <= REG_RESET;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        ADR_BUS_ROUTE: rdata_q <= route_q;
        ADR_MEM_MODE: rdata_q <= mode_q;
        ADR_SEG_END: rdata_q <= seg_end_q;
        ADR_START_HI: rdata_q <= start_hi_q;
        ADR_START_LO: rdata_q <= start_lo_q;
        ADR_READOUT:
        begin
          if (mem_drives)
          begin
            rdata_q <= 8'(stage2_q);
          end
          else
          begin
            rdata_q <= REG_RESET;
          end
        end
        default: rdata_q <= REG_RESET;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign hs_clk_pulse = pulse_q;
  assign hs_bus_data = bus_data_q;
  assign mem_addr = addr_q;

endmodule : acqmr_top

`default_nettype wire

/* File: hdl/acqmr_pkg.sv */
`default_nettype none

package acqmr_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] ADR_BUS_ROUTE = 7'h02;
  localparam logic [6:0] ADR_CLK_STROBE = 7'h08;
  localparam logic [6:0] ADR_READOUT = 7'h0C;
  localparam logic [6:0] ADR_MEM_MODE = 7'h21;
  localparam logic [6:0] ADR_SEG_END = 7'h2B;
  localparam logic [6:0] ADR_START_HI = 7'h2D;
  localparam logic [6:0] ADR_START_LO = 7'h2F;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CLK_SRC_MSB = 3;
  localparam int CLK_SRC_LSB = 2;
  localparam int DATA_SRC_MSB = 1;
  localparam int DATA_SRC_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [10:0] SEG_END_LOW_FILL = 11'h7FF;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    CLK_STROBE = 2'b00,
    CLK_ADC = 2'b01,
    CLK_READOUT = 2'b10,
    CLK_NONE = 2'b11
  } acqmr_clk_src_t;

  typedef enum logic [1:0]
  {
    SRC_ADC = 2'b00,
    SRC_RSVD1 = 2'b01,
    SRC_RSVD2 = 2'b10,
    SRC_MEMORY = 2'b11
  } acqmr_data_src_t;

  typedef enum logic [2:0]
  {
    MODE_IDLE = 3'b000,
    MODE_WRITE = 3'b101,
    MODE_READ = 3'b110
  } acqmr_mem_mode_t;

endpackage : acqmr_pkg

`default_nettype wire

/* File: hdl/acqmr_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module acqmr_mem
  import acqmr_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
)
(
  // clock
  input wire logic sys_clk,
  // access port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data_q
);

  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

  // ----------------------------------------
  // write and first transfer stage
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      store[addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rd_en)
    begin
      rd_data_q <= store[addr];
    end
  end

endmodule : acqmr_mem

`default_nettype wire

/* File: verif/acqmr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module acqmr_monitor
  import acqmr_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // converter and bus
  input wire logic adc_sample_stb,
  input wire logic [DATA_W-1:0] adc_data,
  input wire logic hs_clk_pulse,
  input wire logic [DATA_W-1:0] hs_bus_data,
  input wire logic [ADDR_W-1:0] mem_addr
);
  logic [3:0] route_q;
  logic [2:0] mode_q;
  logic [7:0] hi_q;
  logic e0_q, tick, ld, mv, rdo;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      route_q <= 4'h0;
      mode_q <= 3'h0;
      hi_q <= 8'h00;
      e0_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADR_BUS_ROUTE) route_q <= reg_wdata[3:0];
      if (reg_addr == ADR_MEM_MODE) mode_q <= reg_wdata[2:0];
      if (reg_addr == ADR_START_HI) hi_q <= reg_wdata;
      if (reg_addr == ADR_SEG_END) e0_q <= reg_wdata[0];
    end
  end
  assign rdo = reg_rd && reg_addr == ADR_READOUT;
  assign tick = (route_q[3:2] == 2'b00 && (reg_wr || reg_rd) && reg_addr == ADR_CLK_STROBE)
    || (route_q[3:2] == 2'b01 && adc_sample_stb) || (route_q[3:2] == 2'b10 && rdo);
  assign ld = reg_wr && reg_addr == ADR_START_LO;
  assign mv = tick && (mode_q == MODE_WRITE || mode_q == MODE_READ);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_TICK_ON: assert property (tick |=> hs_clk_pulse)
    else $error("bus clock pulse missing");
  AST_TICK_OFF: assert property (!tick |=> !hs_clk_pulse)
    else $error("extra bus clock pulse");
  AST_ADDR_STEP: assert property (
    mv && mode_q == MODE_WRITE && !ld |=> mem_addr == $past(mem_addr) + 1'b1)
    else $error("address counter did not step");
  AST_ADDR_HOLD: assert property (!mv && !ld |=> $stable(mem_addr))
    else $error("address counter moved");
  AST_BASE_LOAD: assert property (
    ld |=> mem_addr == ADDR_W'({e0_q, hi_q, $past(reg_wdata), 2'b00}))
    else $error("base address wrong");
  AST_GATED: assert property (rdo && route_q[1:0] != 2'b11 |=> reg_rdata == 8'h00)
    else $error("readout not gated");
  AST_BUS_OUT: assert property (rdo && route_q == 4'hB |=> hs_bus_data == reg_rdata)
    else $error("bus data not returned");
  AST_STROBE_RD: assert property (
    reg_rd && reg_addr == ADR_CLK_STROBE |=> reg_rdata == 8'h00)
    else $error("strobe read not zero");
  AST_ROUTE_RD: assert property (
    reg_rd && reg_addr == ADR_BUS_ROUTE |=> reg_rdata[3:0] == $past(route_q))
    else $error("route readback wrong");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed");
  cover property (ld);
  cover property (tick && mode_q == MODE_READ);
  cover property (rdo && route_q == 4'hB);
endmodule : acqmr_monitor
bind acqmr_top acqmr_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) acqmr_monitor_inst (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_sample_stb(adc_sample_stb),
  .adc_data(adc_data), .hs_clk_pulse(hs_clk_pulse), .hs_bus_data(hs_bus_data),
  .mem_addr(mem_addr));
`default_nettype wire

/* File: verif/acqmr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module acqmr_host
(
  // clock and answer
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  // request
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle access, lines scrambled when released
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask : acc
endmodule : acqmr_host
`default_nettype wire

/* File: verif/acqmr_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
module acqmr_tb_top
  import acqmr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic adc_sample_stb = 1'b0;
  logic [7:0] adc_data = 8'h00;
  logic [6:0] reg_addr;
  logic reg_wr, reg_rd, hs_clk_pulse;
  logic [7:0] reg_wdata, reg_rdata, hs_bus_data, q, te, hi, lo;
  logic [18:0] mem_addr, start;
  logic [7:0] exp_q [16];
  int errors = 0;
  int tests_run = 0;
  int n;
  always #12.5 sys_clk = ~sys_clk;
  acqmr_top acqmr_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_sample_stb(adc_sample_stb), .adc_data(adc_data), .hs_clk_pulse(hs_clk_pulse),
    .hs_bus_data(hs_bus_data), .mem_addr(mem_addr));
  acqmr_host acqmr_host_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    acqmr_host_inst.acc(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    acqmr_host_inst.acc(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic load_seg;
    wr(ADR_SEG_END, te);
    wr(ADR_START_HI, hi);
    wr(ADR_START_LO, lo);
  endtask : load_seg
  function automatic void calc(input int sz);
    int s4;
    start = 19'(524287 - sz + 1);
    s4 = int'(start) / 4;
    te = 8'(254 + (s4 > 65535));
    hi = s4[15:8];
    lo = s4[7:0];
  endfunction : calc
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(19013));
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    `CHK("reset rdata", 8'h00, reg_rdata)
    `CHK("reset addr", 19'h00000, mem_addr)
    for (int r = 0; r < 3; r++)
    begin
      n = (r == 0) ? 4 : 4 * (1 + $urandom % 4);
      calc(n);
      wr(ADR_BUS_ROUTE, 8'h00);
      wr(ADR_MEM_MODE, 8'hA8 | 8'(MODE_WRITE));
      load_seg();
      `CHK("base", start, mem_addr)
      for (int i = 0; i < n; i++)
      begin
        adc_data = 8'($urandom);
        exp_q[i] = adc_data;
        if (i[0])
          rd(ADR_CLK_STROBE);
        else
          wr(ADR_CLK_STROBE, 8'($urandom));
      end
      `CHK("wrap", 19'h00000, mem_addr)
      rd(ADR_READOUT);
      `CHK("gated", 8'h00, q)
      rd(7'h10);
      `CHK("unmapped", 8'h00, q)
      wr(ADR_BUS_ROUTE, 8'h03);
      rd(ADR_MEM_MODE);
      `CHK("mode", 8'hAD, q)
      wr(ADR_MEM_MODE, (q & 8'hF8) | 8'(MODE_READ));
      load_seg();
      rd(ADR_CLK_STROBE);
      `CHK("strobe read", 8'h00, q)
      wr(ADR_CLK_STROBE, 8'h5A);
      wr(ADR_CLK_STROBE, 8'hA5);
      wr(ADR_BUS_ROUTE, 8'h0B);
      for (int i = 0; i < n; i++)
      begin
        rd(ADR_READOUT);
        `CHK("reading", exp_q[i], q)
        `CHK("bus data", exp_q[i], hs_bus_data)
      end
      $display("test round %0d done", r);
    end
    // converter as bus clock, then no clock source
    wr(ADR_BUS_ROUTE, 8'h04);
    @(negedge sys_clk);
    adc_sample_stb = 1'b1;
    adc_data = 8'($urandom);
    exp_q[0] = adc_data;
    @(negedge sys_clk);
    adc_sample_stb = 1'b0;
    `CHK("adc pulse", 1'b1, hs_clk_pulse)
    `CHK("adc bus data", exp_q[0], hs_bus_data)
    wr(ADR_CLK_STROBE, 8'($urandom));
    `CHK("strobe not clock", 1'b0, hs_clk_pulse)
    wr(ADR_BUS_ROUTE, 8'h0C);
    rd(ADR_READOUT);
    `CHK("readout not clock", 1'b0, hs_clk_pulse)
    `CHK("readout gated", 8'h00, q)
    $display("test clock sources done");
    // reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    `CHK("reset pulse", 1'b0, hs_clk_pulse)
    `CHK("reset bus data", 8'h00, hs_bus_data)
    `CHK("reset addr again", 19'h00000, mem_addr)
    `CHK("reset rdata again", 8'h00, reg_rdata)
    $display("test mid-run reset done");
    close_out();
  end
endmodule : acqmr_tb_top
`default_nettype wire
